/* core/adc_ctrl_regs.vh */
`ifndef ADC_CTRL_REGS_VH
`define ADC_CTRL_REGS_VH

// control byte field positions
`define CCW_PD_HI 7
`define CCW_PD_LO 6
`define CCW_ACQ 5
`define CCW_CFG 4
`define CCW_POL 3
`define CCW_CH_HI 2
`define CCW_CH_LO 0
`define CCW_WIDTH 8

// control byte after reset: normal operation, external clock
`define CCW_RESET 8'hC0

// result and buffer shape
`define RESULT_WIDTH 12
`define FIFO_DEPTH 16
`define FIFO_AW 4

// timing
`define SYS_CLK_NS 50
`define CONV_CYCLES 13
`define ACQ_EDGES 4
`define INT_CONV_NS 3600
`define INT_STEP_CYC ((`INT_CONV_NS + `CONV_CYCLES * `SYS_CLK_NS - 1) / (`CONV_CYCLES * `SYS_CLK_NS))
`define POR_NS 10000
`define POR_CYC ((`POR_NS + `SYS_CLK_NS - 1) / `SYS_CLK_NS)

`endif

/* core/sample_fifo.v */
`timescale 1ns/1ps
module sample_fifo #(
    parameter WIDTH = 12,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    // clock and reset
    input wire sys_clk,
    input wire rst,
    // fill side
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    // drain side
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    localparam [AW:0] FULL_COUNT = DEPTH[AW:0];

    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr;
    reg [AW-1:0] rd_ptr;
    reg [AW:0] count;
    wire do_push;
    wire do_pop;

    assign in_ready = (count != FULL_COUNT);
    assign out_valid = (count != {(AW+1){1'b0}});
    assign out_data = mem[rd_ptr];
    assign do_push = in_valid && in_ready;
    assign do_pop = out_valid && out_ready;

    always @(posedge sys_clk) begin
        if (do_push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always @(posedge sys_clk) begin
        if (rst) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
        end else begin
            if (do_push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (do_pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            if (do_push && !do_pop) begin
                count <= count + 1'b1;
            end else if (do_pop && !do_push) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule

/* core/adc_conversion_control.v */
// Behaviour
// - every conversion lasts exactly 13 conversion clock ticks in any mode
// - a control byte written mid-conversion aborts it and, unless it selects power-down, starts new acquisition
// - acquisition bit clear: acquisition is timed internally, conversion follows at once
// - acquisition bit set opens acquisition; next write with it clear starts conversion
// - interrupt goes low once a result is complete and ready to read
// - interrupt returns high on the first read or on a new control byte
// - power-down selections leave the last requested clock mode in place
// - the device comes up in external clock mode
// - interrupt high after reset; 10 us reset wait, no conversions meanwhile
// - power bits 10 select internal clock, about 3.9 us per conversion
// - power bits 11 select external clock, steps follow the clock pin
// - chip select high: clock, write, read ignored and data pins released
// - write captures power, acquisition, input, polarity and channel fields
// - 12-bit result, straight binary unipolar, two's complement bipolar
// - in either power-down mode the interface works but nothing converts
// - from standby the next write rising edge powers the device up
// - power bits: 00 full down, 01 standby, 10 internal, 11 external
// - track on write rise; internal acquisition holds on fourth falling clock edge
// - from full power-down a write rising edge returns to normal operation
`timescale 1ns/1ps
`include "adc_ctrl_regs.vh"
module adc_conversion_control (
    // clock and reset
    input wire sys_clk,
    input wire rst,
    // host strobes
    input wire cs_n,
    input wire wr_n,
    input wire rd_n,
    input wire conv_clk,
    // shared data pins
    input wire [7:0] data_in,
    output reg [11:0] data_out,
    output reg [11:0] data_oe_n,
    output reg int_n,
    // analog core
    input wire comp_in,
    output reg [11:0] dac_code,
    output reg track_hold,
    output reg [2:0] channel_sel,
    output reg input_config_sel,
    output reg polarity_sel,
    output reg full_shutdown,
    output reg standby
);
    localparam [5:0] S_POR = 6'h01;
    localparam [5:0] S_IDLE = 6'h02;
    localparam [5:0] S_ACQI = 6'h04;
    localparam [5:0] S_ACQE = 6'h08;
    localparam [5:0] S_CONV = 6'h10;
    localparam [5:0] S_DONE = 6'h20;

    // end points worked out wide, then cut to their counters on purpose
    localparam integer ACQ_END = `ACQ_EDGES - 1;
    localparam integer CONV_END = `CONV_CYCLES - 1;
    localparam integer STEP_END = `INT_STEP_CYC - 1;
    localparam integer POR_END = `POR_CYC - 1;
    localparam [3:0] ACQ_LAST = ACQ_END[3:0];
    localparam [3:0] CONV_LAST = CONV_END[3:0];
    localparam [2:0] STEP_LAST = STEP_END[2:0];
    localparam [7:0] POR_LAST = POR_END[7:0];
    localparam [12:0] PIN_IDLE = 13'h0F00;
    localparam [11:0] SAR_FIRST = 12'h800;

    // pin filter: bits 7..0 data, 8 cs, 9 wr, 10 rd, 11 clock, 12 comparator
    wire [12:0] pins_raw;
    reg [12:0] sync1;
    reg [12:0] sync2;
    reg [12:0] sync3;
    reg [12:0] pin_f;

    assign pins_raw = {comp_in, conv_clk, rd_n, wr_n, cs_n, data_in};

    genvar i;
    generate
        for (i = 0; i < 13; i = i + 1) begin : pin_filter
            always @(posedge sys_clk) begin
                if (rst) begin
                    sync1[i] <= PIN_IDLE[i];
                    sync2[i] <= PIN_IDLE[i];
                    sync3[i] <= PIN_IDLE[i];
                    pin_f[i] <= PIN_IDLE[i];
                end else begin
                    sync1[i] <= pins_raw[i];
                    sync2[i] <= sync1[i];
                    sync3[i] <= sync2[i];
                    if (sync2[i] == sync3[i]) begin
                        pin_f[i] <= sync3[i];
                    end
                end
            end
        end
    endgenerate

    wire [7:0] byte_f;
    wire cs_f;
    wire wr_f;
    wire rd_f;
    wire clk_f;
    wire comp_f;
    assign byte_f = pin_f[7:0];
    assign cs_f = pin_f[8];
    assign wr_f = pin_f[9];
    assign rd_f = pin_f[10];
    assign clk_f = pin_f[11];
    assign comp_f = pin_f[12];

    reg wr_prev;
    reg rd_prev;
    reg clk_prev;

    always @(posedge sys_clk) begin
        if (rst) begin
            wr_prev <= 1'b1;
            rd_prev <= 1'b1;
            clk_prev <= 1'b1;
        end else begin
            wr_prev <= wr_f;
            rd_prev <= rd_f;
            clk_prev <= clk_f;
        end
    end

    // strobes only count with chip select low
    wire wr_rise;
    wire rd_fall;
    wire read_active;
    wire ext_fall;
    assign wr_rise = !cs_f && !wr_prev && wr_f;
    assign rd_fall = !cs_f && rd_prev && !rd_f;
    assign read_active = !cs_f && !rd_f;
    assign ext_fall = !cs_f && clk_prev && !clk_f;

    // control state
    reg [5:0] state;
    reg [7:0] conversion_control_word;
    reg ext_clk_mode;
    reg [7:0] por_cnt;
    reg [2:0] div_cnt;
    reg [3:0] tick_cnt;
    reg [11:0] result;
    reg fifo_in_valid;

    wire acquisition_mode_sel;
    wire power_ctl_hi;
    wire power_ctl_lo;
    assign acquisition_mode_sel = byte_f[`CCW_ACQ];
    assign power_ctl_hi = byte_f[`CCW_PD_HI];
    assign power_ctl_lo = byte_f[`CCW_PD_LO];

    // internal clock restarts on each write so acquisition length is repeatable
    wire int_tick;
    assign int_tick = (div_cnt == STEP_LAST);

    always @(posedge sys_clk) begin
        if (rst || wr_rise || int_tick) begin
            div_cnt <= 3'h0;
        end else begin
            div_cnt <= div_cnt + 1'b1;
        end
    end

    // one tick per falling edge of the conversion clock in external mode, one per divider wrap in internal mode
    wire tick;
    assign tick = ext_clk_mode ? ext_fall : int_tick;

    wire fifo_in_ready;
    wire fifo_out_valid;
    wire [11:0] fifo_out_data;
    wire fifo_push;
    wire fifo_pop;
    assign fifo_push = fifo_in_valid && fifo_in_ready;
    assign fifo_pop = rd_fall && fifo_out_valid;

    wire [3:0] bit_idx;
    wire [11:0] final_code;
    assign bit_idx = CONV_LAST - tick_cnt;
    assign final_code = {dac_code[11:1], comp_f};

    always @(posedge sys_clk) begin
        if (rst) begin
            state <= S_POR;
            conversion_control_word <= `CCW_RESET;
            ext_clk_mode <= 1'b1;
            por_cnt <= 8'h00;
            tick_cnt <= 4'h0;
            dac_code <= 12'h000;
            result <= 12'h000;
            track_hold <= 1'b0;
            fifo_in_valid <= 1'b0;
        end else begin
            if (fifo_push) begin
                fifo_in_valid <= 1'b0;
            end
            if (state == S_POR) begin
                // writes during the reset wait are dropped
                if (por_cnt == POR_LAST) begin
                    state <= S_IDLE;
                end else begin
                    por_cnt <= por_cnt + 1'b1;
                end
            end else if (wr_rise) begin
                // limitation: a write that lands in S_DONE drops the finished result
                conversion_control_word <= byte_f;
                tick_cnt <= 4'h0;
                if (power_ctl_hi) begin
                    ext_clk_mode <= power_ctl_lo;
                end
                if (state == S_ACQE && !acquisition_mode_sel) begin
                    // second write ends acquisition; its clock mode applies at once, power-down afterwards
                    state <= S_CONV;
                    track_hold <= 1'b0;
                    dac_code <= SAR_FIRST;
                end else if (!power_ctl_hi) begin
                    state <= S_IDLE;
                    track_hold <= 1'b0;
                end else if (acquisition_mode_sel) begin
                    state <= S_ACQE;
                    track_hold <= 1'b1;
                end else begin
                    state <= S_ACQI;
                    track_hold <= 1'b1;
                end
            end else begin
                case (state)
                    S_ACQI: begin
                        if (tick) begin
                            if (tick_cnt == ACQ_LAST) begin
                                state <= S_CONV;
                                track_hold <= 1'b0;
                                tick_cnt <= 4'h0;
                                dac_code <= SAR_FIRST;
                            end else begin
                                tick_cnt <= tick_cnt + 1'b1;
                            end
                        end
                    end
                    S_CONV: begin
                        // tick 0 switches the hold capacitor, ticks 1..12 decide a bit each
                        if (tick) begin
                            if (tick_cnt != 4'h0) begin
                                dac_code[bit_idx] <= comp_f;
                                if (bit_idx != 4'h0) begin
                                    dac_code[bit_idx - 1'b1] <= 1'b1;
                                end
                            end
                            if (tick_cnt == CONV_LAST) begin
                                state <= S_DONE;
                                if (conversion_control_word[`CCW_POL]) begin
                                    result <= final_code;
                                end else begin
                                    result <= {~final_code[11], final_code[10:0]};
                                end
                            end else begin
                                tick_cnt <= tick_cnt + 1'b1;
                            end
                        end
                    end
                    S_DONE: begin
                        // an earlier word still waiting on a full buffer holds this result here until a read frees a slot
                        if (!fifo_in_valid) begin
                            fifo_in_valid <= 1'b1;
                            state <= S_IDLE;
                        end
                    end
                    S_ACQE: begin
                        state <= S_ACQE;
                    end
                    S_IDLE: begin
                        state <= S_IDLE;
                    end
                    default: begin
                        state <= S_IDLE;
                    end
                endcase
            end
        end
    end

    // the pushed word is whatever result holds when the buffer takes it
    sample_fifo #(
        .WIDTH(`RESULT_WIDTH),
        .DEPTH(`FIFO_DEPTH),
        .AW(`FIFO_AW)
    ) result_buffer (
        .sys_clk(sys_clk),
        .rst(rst),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(result),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_out_data)
    );

    // completion flag: a push in the same cycle as a release wins
    always @(posedge sys_clk) begin
        if (rst) begin
            int_n <= 1'b1;
        end else if (fifo_push) begin
            int_n <= 1'b0;
        end else if (rd_fall || wr_rise) begin
            int_n <= 1'b1;
        end
    end

    // read port: an empty buffer repeats the last word read
    always @(posedge sys_clk) begin
        if (rst) begin
            data_out <= 12'h000;
            data_oe_n <= 12'hFFF;
        end else begin
            if (fifo_pop) begin
                data_out <= fifo_out_data;
            end
            if (read_active) begin
                data_oe_n <= 12'h000;
            end else begin
                data_oe_n <= 12'hFFF;
            end
        end
    end

    // analog control follows the stored byte; power flags only while idle
    always @(posedge sys_clk) begin
        if (rst) begin
            channel_sel <= 3'h0;
            input_config_sel <= 1'b0;
            polarity_sel <= 1'b0;
            full_shutdown <= 1'b0;
            standby <= 1'b0;
        end else begin
            channel_sel <= conversion_control_word[`CCW_CH_HI:`CCW_CH_LO];
            input_config_sel <= conversion_control_word[`CCW_CFG];
            polarity_sel <= conversion_control_word[`CCW_POL];
            // a write drops both flags at once, so they never overlap new tracking
            full_shutdown <= (state == S_IDLE) && !wr_rise &&
                (conversion_control_word[`CCW_PD_HI:`CCW_PD_LO] == 2'h0);
            standby <= (state == S_IDLE) && !wr_rise &&
                (conversion_control_word[`CCW_PD_HI:`CCW_PD_LO] == 2'h1);
        end
    end
endmodule

/* sim/conv_ctl_assertions.sv */
`timescale 1ns/1ps
module conv_ctl_checker (
    // clock and reset
    input wire sys_clk,
    input wire rst,
    // host pins
    input wire cs_n,
    input wire wr_n,
    input wire rd_n,
    input wire [7:0] data_in,
    // device outputs
    input wire [11:0] data_oe_n,
    input wire int_n,
    input wire track_hold,
    input wire full_shutdown,
    input wire standby
);
    logic [7:0] por_cnt;
    logic [9:0] hold_cnt;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    // saturating counters, so long idle runs never wrap into a false window
    always @(posedge sys_clk) begin
        if (rst) begin
            por_cnt <= 8'h00;
            hold_cnt <= 10'h000;
        end else begin
            if (por_cnt != 8'hFF) por_cnt <= por_cnt + 8'h01;
            if (track_hold) hold_cnt <= 10'h000;
            else if (hold_cnt != 10'h3FF) hold_cnt <= hold_cnt + 10'h001;
        end
    end
    int_reset_a: assert property ($fell(rst) |-> int_n && data_oe_n == 12'hFFF)
        else $error("flag or bus not idle after reset");
    por_quiet_a: assert property (por_cnt < 8'hC8 |-> int_n && !track_hold)
        else $error("activity during reset wait");
    conv_len_a: assert property ($fell(int_n) |-> hold_cnt >= 10'h04E)
        else $error("conversion shorter than thirteen steps");
    int_release_a: assert property (!int_n && !cs_n && $fell(rd_n) |-> ##[2:8] int_n)
        else $error("flag not released by read");
    track_start_a: assert property (por_cnt > 8'hD2 && !cs_n && $rose(wr_n) && data_in[7]
        && data_in[5] |-> ##[3:8] track_hold)
        else $error("no tracking after write");
    bus_release_a: assert property (cs_n [*6] |-> data_oe_n == 12'hFFF)
        else $error("bus driven while deselected");
    read_drive_a: assert property ((!cs_n && !rd_n) [*8] |-> data_oe_n == 12'h000)
        else $error("bus not driven during read");
    read_idle_a: assert property (rd_n [*6] |-> data_oe_n == 12'hFFF)
        else $error("bus driven without read");
    down_still_a: assert property ((full_shutdown || standby) |-> !track_hold)
        else $error("tracking while powered down");
    power_excl_a: assert property (!(full_shutdown && standby))
        else $error("both power-down flags set");
    cover property ($fell(int_n));
    cover property ($rose(standby));
    cover property ($rose(full_shutdown));
endmodule
bind adc_conversion_control conv_ctl_checker chk (.sys_clk(sys_clk), .rst(rst),
    .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n), .data_in(data_in), .data_oe_n(data_oe_n),
    .int_n(int_n), .track_hold(track_hold), .full_shutdown(full_shutdown),
    .standby(standby));

/* sim/host_model.sv */
`timescale 1ns/1ps
module host_model (
    // clock
    input wire sys_clk,
    // host pins
    output logic cs_n,
    output logic wr_n,
    output logic rd_n,
    output logic conv_clk,
    output logic [7:0] data_in
);
    logic clk_on;
    int ph;
    initial begin
        {cs_n, wr_n, rd_n, conv_clk} = 4'hF;
        data_in = 8'h00;
        clk_on = 1'b0;
        ph = 0;
    end
    task automatic hold(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    // byte held well around the strobe so the pin filter sees one value
    task automatic put_byte(input logic [7:0] b, input logic sel_n);
        data_in <= b;
        cs_n <= sel_n;
        hold(5);
        wr_n <= 1'b0;
        hold(6);
        wr_n <= 1'b1;
        hold(6);
        cs_n <= ~clk_on;
        data_in <= ~b;
        hold(6);
    endtask
    task automatic get_word(input logic sel_n);
        cs_n <= sel_n;
        rd_n <= 1'b0;
        hold(9);
        rd_n <= 1'b1;
        cs_n <= ~clk_on;
        hold(6);
    endtask
    // ticks are ignored while deselected, so stay selected while it runs
    always @(posedge sys_clk) begin
        if (clk_on) begin
            cs_n <= 1'b0;
            ph <= (ph == 13) ? 0 : ph + 1;
            if (ph == 0 || ph == 7) conv_clk <= ~conv_clk;
        end
    end
endmodule

/* sim/adc_parallel_conversion_control_bench.sv */
`timescale 1ns/1ps
module adc_parallel_conversion_control_bench;
    logic sys_clk;
    logic rst;
    logic comp_in;
    wire cs_n, wr_n, rd_n, conv_clk, int_n, track_hold, cfg, pol, fsd, sby;
    wire [7:0] data_in;
    wire [11:0] data_out, data_oe_n, dac_code;
    wire [2:0] chan;
    logic [11:0] target = 12'h000;
    logic [16:0] seed = 17'h10183;
    logic [11:0] exp_q[$];
    logic [11:0] oe_prev = 12'hFFF;
    int err_total = 0;
    int total_checks = 0;
    int cycles = 0;
    always #25 sys_clk = ~sys_clk;
    adc_conversion_control DUT (.sys_clk(sys_clk), .rst(rst), .cs_n(cs_n), .wr_n(wr_n),
        .rd_n(rd_n), .conv_clk(conv_clk), .data_in(data_in), .data_out(data_out),
        .data_oe_n(data_oe_n), .int_n(int_n), .comp_in(comp_in), .dac_code(dac_code),
        .track_hold(track_hold), .channel_sel(chan), .input_config_sel(cfg),
        .polarity_sel(pol), .full_shutdown(fsd), .standby(sby));
    host_model host (.sys_clk(sys_clk), .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n),
        .conv_clk(conv_clk), .data_in(data_in));
    // ideal comparator: keep the trial bit while the code does not exceed the input
    always @(posedge sys_clk) comp_in <= (dac_code <= target);
    function automatic logic [16:0] lfsr(input logic [16:0] s);
        return {s[15:0], s[16] ^ s[13]};
    endfunction
    task automatic chk_word(input logic [11:0] got, input logic [11:0] want);
        total_checks++;
        if (got !== want) begin
            err_total++;
            $display("unexpected at %0t: got %h want %h", $time, got, want);
        end
    endtask
    task automatic chk_bit(input logic got, input logic want);
        chk_word({11'h000, got}, {11'h000, want});
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic conv(input logic [7:0] b);
        seed = lfsr(seed);
        target <= seed[11:0];
        exp_q.push_back(seed[11:0] ^ (b[3] ? 12'h000 : 12'h800));
        host.put_byte(b, 1'b0);
    endtask
    task automatic wait_int(input int n);
        int i;
        for (i = 0; i < n && int_n !== 1'b0; i++) @(posedge sys_clk);
        chk_bit(int_n, 1'b0);
    endtask
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_total++;
            finish_test;
        end
    end
    always @(negedge sys_clk) begin
        if (data_oe_n === 12'h000 && oe_prev !== 12'h000) begin
            chk_word(data_out, exp_q.size() > 0 ? exp_q.pop_front() : 12'hXXX);
        end
        oe_prev = data_oe_n;
    end
    initial begin
        sys_clk = 1'b0;
        rst = 1'b1;
        repeat (16) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (40) @(posedge sys_clk);
        host.put_byte(8'h98, 1'b0);
        repeat (170) @(posedge sys_clk);
        chk_bit(track_hold, 1'b0);
        for (int i = 0; i < 17; i++) begin
            conv({3'b100, i[1:0], i[2:0]});
            repeat (110) @(posedge sys_clk);
            chk_word({7'h00, cfg, pol, chan}, {7'h00, i[1:0], i[2:0]});
        end
        // sixteen queued, the last one waits for a free slot
        repeat (17) host.get_word(1'b0);
        chk_bit(int_n, 1'b1);
        host.put_byte(8'h98, 1'b0);
        repeat (40) @(posedge sys_clk);
        conv(8'h9D);
        wait_int(150);
        host.get_word(1'b0);
        chk_bit(int_n, 1'b1);
        host.put_byte(8'hB8, 1'b1);
        host.get_word(1'b1);
        chk_bit(track_hold, 1'b0);
        host.clk_on <= 1'b1;
        conv(8'hD8);
        wait_int(400);
        host.get_word(1'b0);
        host.clk_on <= 1'b0;
        conv(8'hD4);
        repeat (300) @(posedge sys_clk);
        chk_bit(int_n, 1'b1);
        host.clk_on <= 1'b1;
        wait_int(400);
        host.get_word(1'b0);
        host.clk_on <= 1'b0;
        host.put_byte(8'hB9, 1'b0);
        repeat (100) @(posedge sys_clk);
        chk_bit(track_hold, 1'b1);
        conv(8'h19);
        wait_int(150);
        repeat (4) @(posedge sys_clk);
        chk_bit(fsd, 1'b1);
        host.put_byte(8'h58, 1'b0);
        chk_bit(int_n, 1'b1);
        chk_bit(sby, 1'b1);
        repeat (150) @(posedge sys_clk);
        chk_bit(int_n, 1'b1);
        conv(8'h98);
        wait_int(150);
        repeat (2) host.get_word(1'b0);
        host.put_byte(8'h18, 1'b0);
        conv(8'h9A);
        wait_int(150);
        host.get_word(1'b0);
        chk_word(12'(exp_q.size()), 12'h000);
        finish_test;
    end
endmodule
